/* rtl/pushbutton_ldo_pkg.sv */
`default_nettype none
package pushbutton_ldo_pkg;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h07;
    localparam logic [7:0] PB_CTRL_ADDR = 8'h08;
    localparam logic [7:0] AUX_CTRL_RST = 8'h7C;
    localparam logic [7:0] PB_CTRL_RST = 8'h68;
    localparam int AUX_EN_BIT = 7;
    localparam int AUX_CODE_MSB = 6;
    localparam int AUX_CODE_LSB = 2;
    localparam int AUX_RSVD_BIT = 1;
    localparam int NEEDS_INPUT_BIT = 0;
    localparam int FIRST_WAKE_FLAG_SEL_BIT = 7;
    localparam int SECOND_WAKE_FLAG_SEL_BIT = 6;
    localparam int POST_RST_BIT = 5;
    localparam int RST_TIME_MSB = 4;
    localparam int RST_TIME_LSB = 3;
    localparam int SHARED_SEL_BIT = 2;
    localparam int FIRST_WAKE_FLAG_FLAG_BIT = 1;
    localparam int SECOND_WAKE_FLAG_FLAG_BIT = 0;
    localparam logic [11:0] AUX_BASE_MV = 12'h320;
    localparam logic [11:0] AUX_STEP_MV = 12'h064;
    localparam logic [11:0] AUX_PASS_MV = 12'hCE4;
    localparam logic [11:0] MAIN_R0_C0_MV = 12'h44C;
    localparam logic [11:0] MAIN_R0_C1_MV = 12'h4B0;
    localparam logic [11:0] MAIN_R0_BASE_MV = 12'h4E2;
    localparam logic [11:0] MAIN_R1_BASE_MV = 12'h514;
    localparam logic [11:0] MAIN_R2_BASE_MV = 12'h5DC;
    localparam logic [11:0] MAIN_R3_BASE_MV = 12'h708;
    localparam logic [13:0] MAIN_STEP_MV = 14'h0064;
    localparam logic [13:0] THIRD_NUM = 14'h00FA;
    localparam logic [13:0] THIRD_DEN = 14'h0003;
    localparam logic [13:0] FIRST_WAKE_FLAG_SHORT_MS = 14'h0050;
    localparam logic [13:0] FIRST_WAKE_FLAG_LONG_MS = 14'h0258;
    localparam logic [13:0] SECOND_WAKE_FLAG_SHORT_MS = 14'h03E8;
    localparam logic [13:0] SECOND_WAKE_FLAG_LONG_MS = 14'h05DC;
    localparam logic [13:0] RESET_5S_MS = 14'h1388;
    localparam logic [13:0] RESET_9S_MS = 14'h2328;
    localparam logic [13:0] RESET_11S_MS = 14'h2AF8;
    localparam logic [13:0] RESET_15S_MS = 14'h3A98;
    localparam int CLOCK_HZ = 125_000_000;
    localparam int MS_CYCLES = CLOCK_HZ / 1000;
    localparam int MS_CNT_W = 17;
    localparam logic [4:0] SYNC_RST = 5'h07;
    typedef enum {PH_IDLE, PH_ADDR, PH_PTR, PH_WRITE, PH_READ} i2c_phase_e;

    function automatic logic [11:0] mainDecodeMv(input logic [1:0] rng, input logic [3:0] code);
        logic [13:0] c;
        logic [13:0] thirds;
        c = {10'h000, code};
        thirds = (c * THIRD_NUM + 14'h0001) / THIRD_DEN;
        unique case (rng)
            2'h0: mainDecodeMv = (code == 4'h0) ? MAIN_R0_C0_MV :
                (code == 4'h1) ? MAIN_R0_C1_MV :
                12'(MAIN_R0_BASE_MV + ((c - 14'h0002) * THIRD_NUM + 14'h0001) / THIRD_DEN);
            2'h1: mainDecodeMv = 12'(MAIN_R1_BASE_MV + c * MAIN_STEP_MV);
            2'h2: mainDecodeMv = 12'(MAIN_R2_BASE_MV + thirds);
            2'h3: mainDecodeMv = 12'(MAIN_R3_BASE_MV + c * MAIN_STEP_MV);
        endcase
    endfunction
endpackage
`default_nettype wire

/* rtl/pushbutton_ldo_control_regs.sv */
// Function
// - The main output range select and code decode into one of sixteen voltages per range.
// - The aux output control register sits at 0x07 and resets with bits 6..2 set, bit 1 clear.
// - Bit 7 of the aux output control register enables the aux output and resets to zero.
// - The aux code in bits 6..2 weighs 100 mV to 1600 mV above a fixed base voltage.
// - An aux code above 3.3 V selects pass-through mode instead of regulation.
// - The aux code changes only while both the enable bit and the control pin hold it off.
// - Bit 0 of the aux register makes the button reset also need a valid input supply.
// - The pushbutton control register sits at 0x08 and resets bits 7..2 to 011010.
// - Bit 7 picks the first wake hold threshold, 80 ms or 600 ms.
// - Bit 6 picks the second wake hold threshold, 1000 ms or 1500 ms, resetting to one.
// - Bit 5 picks ship state (0) or high-impedance state (1) after a button reset.
// - Bits 4..3 pick the reset hold time of 5 s, 9 s, 11 s or 15 s.
// - Bit 2 makes the shared pin power good (0) or a copy of the button input (1).
// - Bit 1 flags the first wake condition and clears when the host reads it.
// - Bit 0 flags the second wake condition and clears when the host reads it.
`default_nettype none
module pushbutton_ldo_control_regs
    import pushbutton_ldo_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic pushbuttonN,
    input wire logic inputSupplyValid,
    input wire logic auxOutputControlPin,
    input wire logic powerGoodN,
    input wire logic [1:0] mainOutputRangeSelect,
    input wire logic [3:0] mainOutputVoltageCode,
    output logic auxOutputEnable,
    output logic [4:0] auxOutputVoltageCode,
    output logic [11:0] auxVoltageMv,
    output logic auxPassThrough,
    output logic [11:0] mainVoltageMv,
    output logic buttonResetPulse,
    output logic postResetHighZ,
    output logic sharedPinOut,
    output logic firstWakeFlag,
    output logic secondWakeFlag
);
    logic [4:0] sync1_r, sync2_r, sync3_r, filt_r;
    wire logic [4:0] rawIn;
    wire logic [4:0] agree;
    wire logic [4:0] filtNxt;
    wire logic [4:0] rise;
    wire logic [4:0] fall;
    // Bit order: scl, sda, button, supply, control pin
    assign rawIn = {auxOutputControlPin, inputSupplyValid, pushbuttonN, sdaIn, sclIn};
    assign agree = ~(sync2_r ^ sync3_r);
    assign filtNxt = (filt_r & ~agree) | (sync3_r & agree);
    assign rise = filtNxt & ~filt_r;
    assign fall = filt_r & ~filtNxt;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sync3_r <= SYNC_RST;
            filt_r <= SYNC_RST;
        end
        else if (clockEn)
        begin
            sync1_r <= rawIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= filtNxt;
        end
    end

    wire logic sclRise = rise[0];
    wire logic sclFall = fall[0];
    wire logic sclHigh = filt_r[0] && filtNxt[0];
    wire logic busStart = fall[1] && sclHigh;
    wire logic busStop = rise[1] && sclHigh;
    wire logic pressed = !filt_r[2];
    wire logic supplyOk = filt_r[3];
    wire logic pinOn = filt_r[4];

    i2c_phase_e phase_r;
    logic [3:0] bitCnt_r;
    logic inAck_r, nack_r, sdaOut_r, sdaOe_r;
    logic [7:0] rxByte_r, txByte_r, ptr_r;
    logic [7:0] auxCtl_r, pbCtl_r;
    wire logic [7:0] readByte;
    wire logic active = (phase_r != PH_IDLE) && !busStart && !busStop;
    wire logic byteEnd = active && sclFall && !inAck_r && (bitCnt_r == 4'h8);
    wire logic loadNow = active && sclFall && inAck_r && (phase_r == PH_READ) && !nack_r;
    wire logic wrNow = byteEnd && (phase_r == PH_WRITE);
    wire logic wrAux = wrNow && (ptr_r == AUX_CTRL_ADDR);
    wire logic wrPb = wrNow && (ptr_r == PB_CTRL_ADDR);
    wire logic clearFlags = loadNow && (ptr_r == PB_CTRL_ADDR);
    wire logic addrMatch = (rxByte_r[7:1] == DEV_ADDR);
    // Unmapped offsets read as zero
    assign readByte = (ptr_r == AUX_CTRL_ADDR) ? auxCtl_r :
        (ptr_r == PB_CTRL_ADDR) ? pbCtl_r : 8'h00;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            phase_r <= PH_IDLE;
            bitCnt_r <= 4'h0;
            inAck_r <= 1'b0;
            nack_r <= 1'b0;
            rxByte_r <= 8'h00;
            txByte_r <= 8'h00;
            ptr_r <= 8'h00;
            sdaOut_r <= 1'b1;
            sdaOe_r <= 1'b0;
        end
        else if (clockEn)
        begin
            if (busStop)
            begin
                phase_r <= PH_IDLE;
                sdaOe_r <= 1'b0;
            end
            else if (busStart)
            begin
                phase_r <= PH_ADDR;
                bitCnt_r <= 4'h0;
                inAck_r <= 1'b0;
                sdaOe_r <= 1'b0;
            end
            else if (phase_r != PH_IDLE)
            begin
                if (sclRise && inAck_r)
                    nack_r <= filtNxt[1];
                else if (sclRise)
                begin
                    rxByte_r <= {rxByte_r[6:0], filtNxt[1]};
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
                else if (sclFall && inAck_r)
                begin
                    inAck_r <= 1'b0;
                    bitCnt_r <= 4'h0;
                    txByte_r <= readByte;
                    sdaOut_r <= readByte[7];
                    sdaOe_r <= loadNow && !readByte[7];
                    if (phase_r == PH_READ && nack_r)
                        phase_r <= PH_IDLE;
                end
                else if (byteEnd)
                begin
                    inAck_r <= 1'b1;
                    sdaOut_r <= 1'b0;
                    sdaOe_r <= (phase_r != PH_READ) && (phase_r != PH_ADDR || addrMatch);
                    unique case (phase_r)
                        PH_IDLE: ;
                        PH_ADDR:
                        begin
                            nack_r <= 1'b0;
                            phase_r <= !addrMatch ? PH_IDLE : rxByte_r[0] ? PH_READ : PH_PTR;
                        end
                        PH_PTR:
                        begin
                            ptr_r <= rxByte_r;
                            phase_r <= PH_WRITE;
                        end
                        PH_WRITE: ptr_r <= ptr_r + 8'h01;
                        PH_READ: ptr_r <= ptr_r + 8'h01;
                    endcase
                end
                else if (sclFall && phase_r == PH_READ)
                begin
                    txByte_r <= {txByte_r[6:0], 1'b0};
                    sdaOut_r <= txByte_r[6];
                    sdaOe_r <= !txByte_r[6];
                end
            end
        end
    end

    // Hold time is measured in whole milliseconds from the filtered press
    logic [MS_CNT_W-1:0] msCnt_r;
    logic [13:0] holdMs_r;
    logic buttonReset_r;
    wire logic msTick = pressed && (msCnt_r == MS_CNT_W'(MS_CYCLES_P - 1));
    wire logic [13:0] wake1Ms = pbCtl_r[FIRST_WAKE_FLAG_SEL_BIT] ? FIRST_WAKE_FLAG_LONG_MS : FIRST_WAKE_FLAG_SHORT_MS;
    wire logic [13:0] wake2Ms = pbCtl_r[SECOND_WAKE_FLAG_SEL_BIT] ? SECOND_WAKE_FLAG_LONG_MS : SECOND_WAKE_FLAG_SHORT_MS;
    wire logic [1:0] rstSel = pbCtl_r[RST_TIME_MSB:RST_TIME_LSB];
    wire logic [13:0] resetMs = (rstSel == 2'h0) ? RESET_5S_MS :
        (rstSel == 2'h1) ? RESET_9S_MS : (rstSel == 2'h2) ? RESET_11S_MS : RESET_15S_MS;
    // Each event fires once, as the hold count steps past its threshold
    wire logic wake1Ev = msTick && (holdMs_r == wake1Ms);
    wire logic wake2Ev = msTick && (holdMs_r == wake2Ms);
    wire logic resetGate = !auxCtl_r[NEEDS_INPUT_BIT] || supplyOk;
    wire logic resetEv = msTick && (holdMs_r == resetMs) && resetGate;
    wire logic codeUnlocked = !auxCtl_r[AUX_EN_BIT] && !pinOn;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            msCnt_r <= '0;
            holdMs_r <= 14'h0000;
            buttonReset_r <= 1'b0;
        end
        else if (clockEn)
        begin
            msCnt_r <= (!pressed || msTick) ? '0 : msCnt_r + 1'b1;
            if (!pressed)
                holdMs_r <= 14'h0000;
            else if (msTick && holdMs_r != 14'h3FFF)
                holdMs_r <= holdMs_r + 14'h0001;
            buttonReset_r <= resetEv;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            auxCtl_r <= AUX_CTRL_RST;
            pbCtl_r <= PB_CTRL_RST;
        end
        else if (clockEn)
        begin
            if (wrAux)
            begin
                auxCtl_r[AUX_EN_BIT] <= rxByte_r[AUX_EN_BIT];
                auxCtl_r[NEEDS_INPUT_BIT] <= rxByte_r[NEEDS_INPUT_BIT];
                if (codeUnlocked)
                    auxCtl_r[AUX_CODE_MSB:AUX_CODE_LSB] <= rxByte_r[AUX_CODE_MSB:AUX_CODE_LSB];
            end
            if (wrPb)
                pbCtl_r[7:2] <= rxByte_r[7:2];
            // A wake event in the read cycle survives the clear
            pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT] <= wake1Ev || (pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT] && !clearFlags);
            pbCtl_r[SECOND_WAKE_FLAG_FLAG_BIT] <= wake2Ev || (pbCtl_r[SECOND_WAKE_FLAG_FLAG_BIT] && !clearFlags);
        end
    end

    logic [11:0] auxMv_r, mainMv_r;
    logic passThru_r, sharedPin_r;
    wire logic [4:0] auxCode = auxCtl_r[AUX_CODE_MSB:AUX_CODE_LSB];
    wire logic [11:0] auxMvNxt = 12'(AUX_BASE_MV + {7'h00, auxCode} * AUX_STEP_MV);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            auxMv_r <= 12'h000;
            mainMv_r <= 12'h000;
            passThru_r <= 1'b0;
            sharedPin_r <= 1'b1;
        end
        else if (clockEn)
        begin
            auxMv_r <= auxMvNxt;
            passThru_r <= auxMvNxt > AUX_PASS_MV;
            mainMv_r <= mainDecodeMv(mainOutputRangeSelect, mainOutputVoltageCode);
            sharedPin_r <= pbCtl_r[SHARED_SEL_BIT] ? filt_r[2] : powerGoodN;
        end
    end

    assign sdaOut = sdaOut_r;
    assign sdaOe = sdaOe_r;
    assign auxOutputEnable = auxCtl_r[AUX_EN_BIT];
    assign auxOutputVoltageCode = auxCtl_r[AUX_CODE_MSB:AUX_CODE_LSB];
    assign auxVoltageMv = auxMv_r;
    assign auxPassThrough = passThru_r;
    assign mainVoltageMv = mainMv_r;
    assign buttonResetPulse = buttonReset_r;
    assign postResetHighZ = pbCtl_r[POST_RST_BIT];
    assign sharedPinOut = sharedPin_r;
    assign firstWakeFlag = pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT];
    assign secondWakeFlag = pbCtl_r[SECOND_WAKE_FLAG_FLAG_BIT];

    main_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn |=> mainMv_r == $past(mainDecodeMv(mainOutputRangeSelect, mainOutputVoltageCode)))
        else $error("main voltage decode wrong");
    reset_values_a: assert property (@(posedge clock) sys_rst |=>
        auxCtl_r == 8'h7C && pbCtl_r == 8'h68)
        else $error("register reset values wrong");
    aux_voltage_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn |=> auxMv_r == 12'(12'h320 + $past({7'h00, auxCode}) * 12'h064))
        else $error("aux voltage wrong");
    pass_thru_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn |=> passThru_r == ($past(auxCode) > 5'h19))
        else $error("pass-through flag wrong");
    code_lock_a: assert property (@(posedge clock) disable iff (sys_rst)
        (auxCtl_r[AUX_EN_BIT] || pinOn) |=> $stable(auxCode))
        else $error("aux code changed while output on");
    reset_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        buttonReset_r |-> $past(!auxCtl_r[NEEDS_INPUT_BIT] || supplyOk) && $past(pressed))
        else $error("button reset without its conditions");
    wake_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && wake1Ev |=> pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT] ##1
            (pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT] || $past(clearFlags)))
        else $error("first wake flag not held");
    flag_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && clearFlags && !wake2Ev |=> !pbCtl_r[SECOND_WAKE_FLAG_FLAG_BIT])
        else $error("second wake flag not cleared by read");
    shared_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn |=> sharedPin_r == ($past(pbCtl_r[SHARED_SEL_BIT]) ? $past(filt_r[2])
            : $past(powerGoodN)))
        else $error("shared pin source wrong");
    ro_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && (wrPb || wrAux) && !wake1Ev && !clearFlags
            |=> $stable(pbCtl_r[FIRST_WAKE_FLAG_FLAG_BIT]) && !auxCtl_r[AUX_RSVD_BIT])
        else $error("read-only bit changed by write");
endmodule // pushbutton_ldo_control_regs
`default_nettype wire

/* tb/i2c_host_model.sv */
`default_nettype none
module i2c_host_model
(
    input wire logic clock,
    input wire logic sdaOe,
    input wire logic sdaOut,
    output logic sclIn,
    output logic sdaIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sdaDrv = 1'b1;
    int lowExtra = 0;
    // Open-drain wire with pull-up: whichever side pulls low wins
    // A device that enables its driver with a high data value leaves the wire to the pull-up
    assign sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);
    initial sclIn = 1'b1;
    task automatic waitc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Clock stays low longer when lowExtra is set, to act as a slow host
    task automatic bitc(input logic b, output logic got);
        sdaDrv = b;
        waitc(2 + lowExtra);
        sclIn = 1'b1;
        waitc(3);
        got = sdaIn;
        waitc(1);
        sclIn = 1'b0;
        waitc(2);
    endtask
    // Extra wait lets the device drop its acknowledge before the clock rises
    task automatic start();
        sdaDrv = 1'b1;
        waitc(4);
        sclIn = 1'b1;
        waitc(4);
        sdaDrv = 1'b0;
        waitc(4);
        sclIn = 1'b0;
        waitc(2);
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        waitc(2);
        sclIn = 1'b1;
        waitc(4);
        sdaDrv = 1'b1;
        waitc(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] got,
        output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            bitc(d[i], g);
            got[i] = g;
        end
        bitc(ackIn, ack);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* tb/tb_pushbutton_ldo_control_regs.sv */
`default_nettype none
module tb_pushbutton_ldo_control_regs
    import pushbutton_ldo_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = 7'h2A;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clockEn = 1'b1;
    logic sclIn, sdaIn, sdaOut, sdaOe;
    logic pushbuttonN = 1'b1, inputSupplyValid = 1'b0, auxOutputControlPin = 1'b0;
    logic powerGoodN = 1'b0;
    logic [1:0] mainOutputRangeSelect = 2'h0;
    logic [3:0] mainOutputVoltageCode = 4'h0;
    logic auxOutputEnable, auxPassThrough, buttonResetPulse, postResetHighZ;
    logic sharedPinOut, firstWakeFlag, secondWakeFlag;
    logic [4:0] auxOutputVoltageCode;
    logic [11:0] auxVoltageMv, mainVoltageMv;
    logic [7:0] mAux = 8'h7C, mPb = 8'h68;
    int checks = 0, num_errors = 0;
    int rt[4] = '{5000, 9000, 11000, 15000};

    // One ms per clock keeps the long button holds inside the run length
    pushbutton_ldo_control_regs #(.DEV_ADDR(DEV), .MS_CYCLES_P(1)) u_pushbutton_ldo_control_regs (
        .clock(clock), .sys_rst(sys_rst), .clockEn(clockEn), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .pushbuttonN(pushbuttonN),
        .inputSupplyValid(inputSupplyValid), .auxOutputControlPin(auxOutputControlPin),
        .powerGoodN(powerGoodN), .mainOutputRangeSelect(mainOutputRangeSelect),
        .mainOutputVoltageCode(mainOutputVoltageCode), .auxOutputEnable(auxOutputEnable),
        .auxOutputVoltageCode(auxOutputVoltageCode), .auxVoltageMv(auxVoltageMv),
        .auxPassThrough(auxPassThrough), .mainVoltageMv(mainVoltageMv),
        .buttonResetPulse(buttonResetPulse), .postResetHighZ(postResetHighZ),
        .sharedPinOut(sharedPinOut), .firstWakeFlag(firstWakeFlag),
        .secondWakeFlag(secondWakeFlag));
    i2c_host_model u_i2c_host_model (.clock(clock), .sdaOe(sdaOe), .sdaOut(sdaOut),
        .sclIn(sclIn), .sdaIn(sdaIn));

    initial forever #4 clock = ~clock;

    task automatic end_of_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        chk(16'(got >= exp && got <= exp + 12), 16'h1, "timing");
    endtask
    function automatic int mainMv(input int r, input int c);
        if (r == 1) return 1300 + 100 * c;
        if (r == 3) return 1800 + 100 * c;
        if (r == 2) return 1500 + (c * 250 + 1) / 3;
        if (c < 2) return 1100 + 100 * c;
        return 1250 + ((c - 2) * 250 + 1) / 3;
    endfunction
    function automatic void modelWr(input logic [7:0] a, input logic [7:0] d);
        if (a == AUX_CTRL_ADDR)
        begin
            if (!mAux[7] && !auxOutputControlPin) mAux[6:2] = d[6:2];
            mAux[7] = d[7];
            mAux[0] = d[0];
        end
        if (a == PB_CTRL_ADDR) mPb[7:2] = d[7:2];
    endfunction
    task automatic wrb(input logic [7:0] d);
        logic [7:0] g;
        logic k;
        u_i2c_host_model.xfer(d, 1'b1, g, k);
        chk(16'(k), 16'h0, "ack");
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_i2c_host_model.start();
        wrb({DEV, 1'b0});
        wrb(a);
        wrb(d);
        u_i2c_host_model.stop();
        modelWr(a, d);
    endtask
    // Reading the button register clears both wake flags in the model
    task automatic rdChk(input logic [7:0] a);
        logic [7:0] q;
        logic k;
        u_i2c_host_model.start();
        wrb({DEV, 1'b0});
        wrb(a);
        u_i2c_host_model.start();
        wrb({DEV, 1'b1});
        u_i2c_host_model.xfer(8'hFF, 1'b1, q, k);
        u_i2c_host_model.stop();
        chk(16'(q), 16'(a == AUX_CTRL_ADDR ? mAux : a == PB_CTRL_ADDR ? mPb : 8'h00), "read");
        if (a == PB_CTRL_ADDR) mPb[1:0] = 2'b00;
    endtask
    task automatic hold(input int lim, output int w1, output int w2, output int rp);
        w1 = -1;
        w2 = -1;
        rp = -1;
        pushbuttonN = 1'b0;
        for (int n = 0; n < lim; n++)
        begin
            @(negedge clock);
            if (w1 < 0 && firstWakeFlag === 1'b1) w1 = n;
            if (w2 < 0 && secondWakeFlag === 1'b1) w2 = n;
            if (rp < 0 && buttonResetPulse === 1'b1) rp = n;
            if (n == 20) chk(16'(sharedPinOut), 16'(mPb[2] ? 1'b0 : powerGoodN), "pin");
        end
        pushbuttonN = 1'b1;
        repeat (8) @(negedge clock);
    endtask

    initial
    begin
        int w1, w2, rp, thr;
        logic [7:0] d;
        void'($urandom(1));
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        repeat (8) @(negedge clock);
        chk(16'(auxOutputEnable), 16'h0, "enable");
        rdChk(AUX_CTRL_ADDR);
        rdChk(PB_CTRL_ADDR);
        rdChk(8'h0A);
        wr(8'h0A, 8'($urandom));
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 16; c++)
            begin
                mainOutputRangeSelect = 2'(r);
                mainOutputVoltageCode = 4'(c);
                repeat (2) @(negedge clock);
                chk(16'(mainVoltageMv), 16'(mainMv(r, c)), "main");
            end
        // Clock enable low must freeze the registered decode
        clockEn = 1'b0;
        mainOutputRangeSelect = 2'h1;
        repeat (4) @(negedge clock);
        chk(16'(mainVoltageMv), 16'(mainMv(3, 15)), "frozen");
        clockEn = 1'b1;
        repeat (2) @(negedge clock);
        chk(16'(mainVoltageMv), 16'(mainMv(1, 15)), "main");
        // First two writes hit the pass-through boundary, codes 25 and 26
        for (int i = 0; i < 24; i++)
        begin
            auxOutputControlPin = (i > 1) & 1'($urandom);
            d = (i < 2) ? 8'(8'h66 + (i << 2)) : 8'($urandom);
            wr(AUX_CTRL_ADDR, d);
            rdChk(AUX_CTRL_ADDR);
            chk(16'(auxOutputEnable), 16'(mAux[7]), "en");
            chk(16'(auxOutputVoltageCode), 16'(mAux[6:2]), "code");
            chk(16'(auxVoltageMv), 16'(800 + 100 * mAux[6:2]), "auxMv");
            chk(16'(auxPassThrough), 16'(800 + 100 * mAux[6:2] > 3300), "pass");
        end
        u_i2c_host_model.lowExtra = 3;
        for (int i = 0; i < 8; i++)
        begin
            powerGoodN = 1'($urandom);
            wr(PB_CTRL_ADDR, 8'($urandom));
            rdChk(PB_CTRL_ADDR);
            chk(16'(postResetHighZ), 16'(mPb[5]), "state");
            chk(16'(sharedPinOut), 16'(mPb[2] ? pushbuttonN : powerGoodN), "pin");
        end
        u_i2c_host_model.lowExtra = 0;
        for (int s = 0; s < 2; s++)
        begin
            wr(PB_CTRL_ADDR, {s[0], s[0], 1'b0, 2'b00, s[0], 2'b00});
            thr = s ? 1500 : 1000;
            hold(thr + 30, w1, w2, rp);
            near(w1, s ? 600 : 80);
            near(w2, thr);
            chk(16'(rp), 16'hFFFF, "reset");
            mPb[1:0] = 2'b11;
            rdChk(PB_CTRL_ADDR);
            rdChk(PB_CTRL_ADDR);
        end
        // Fourth pass holds code 11 with the supply invalid, so no reset may fire
        for (int k = 0; k < 5; k++)
        begin
            inputSupplyValid = (k == 1);
            wr(AUX_CTRL_ADDR, {mAux[7:1], k[0]});
            wr(PB_CTRL_ADDR, {mPb[7:5], 2'((k == 4) ? 3 : k), mPb[2], 2'b00});
            thr = rt[(k == 4) ? 3 : k];
            hold(thr + 30, w1, w2, rp);
            mPb[1:0] = 2'b11;
            if (k == 3)
                chk(16'(rp), 16'hFFFF, "gated");
            else
                near(rp, thr);
        end
        rdChk(PB_CTRL_ADDR);
        end_of_test();
    end

    initial
    begin
        #790000;
        num_errors++;
        $display("MISMATCH t=%0t run limit reached", $time);
        end_of_test();
    end
endmodule // tb_pushbutton_ldo_control_regs
`default_nettype wire
